// ### pkg/status_alert_pkg.sv
package status_alert_pkg;

  // ----------------------------------------------------------------
  // Width and register pointers
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam logic [7:0] STATUS_PTR = 8'h02;
  localparam logic [7:0] HYST_PTR = 8'h21;

  // ----------------------------------------------------------------
  // Status register field positions
  // ----------------------------------------------------------------
  localparam int BIT_BUSY = 7;
  localparam int BIT_LOCAL_OVER = 6;
  localparam int BIT_LOCAL_UNDER = 5;
  localparam int BIT_REMOTE_OVER = 4;
  localparam int BIT_REMOTE_UNDER = 3;
  localparam int BIT_OPEN = 2;
  localparam int BIT_REMOTE_CRIT = 1;
  localparam int BIT_LOCAL_CRIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] FLAGS_RESET = 5'h00;
  localparam logic [3:0] TRIP_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic PIN_IDLE = 1'b1;

  // ----------------------------------------------------------------
  // Indices of the hysteresis trackers
  // ----------------------------------------------------------------
  localparam int TRIP_LOCAL_CRIT = 0;
  localparam int TRIP_REMOTE_CRIT = 1;
  localparam int TRIP_LOCAL_OVER = 2;
  localparam int TRIP_REMOTE_OVER = 3;
  localparam int TRIP_N = 4;

  // Index of each sticky flag inside the five-flag vector
  localparam int F_LOCAL_OVER = 4;
  localparam int F_LOCAL_UNDER = 3;
  localparam int F_REMOTE_OVER = 2;
  localparam int F_REMOTE_UNDER = 1;
  localparam int F_OPEN = 0;

endpackage

// ### verif/alert_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module alert_host_model (
  // Clock
  input wire logic clock,
  // Host requests
  output var logic reg_rd,
  output var logic [7:0] reg_ptr,
  output var logic addr_read,
  // Device answers
  input wire logic [7:0] status_rdata,
  input wire logic status_rvalid
);
  initial begin
    reg_rd = 1'b0;
    reg_ptr = 8'h00;
    addr_read = 1'b0;
  end

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
    int n;
    @(negedge clock);
    reg_rd = 1'b1;
    reg_ptr = ptr;
    @(negedge clock);
    reg_rd = 1'b0;
    // Released pointer must not keep its old value
    reg_ptr = ~ptr;
    n = 0;
    while (status_rvalid !== 1'b1 && n < 4) begin
      @(negedge clock);
      n++;
    end
    data = (status_rvalid === 1'b1) ? status_rdata : 8'hXX;
  endtask

  task automatic service();
    @(negedge clock);
    addr_read = 1'b1;
    @(negedge clock);
    addr_read = 1'b0;
    repeat (3) @(negedge clock);
  endtask
endmodule

`default_nettype wire

// ### verif/temp_limit_status_alert_test.sv
`timescale 1ns/10ps
`default_nettype none

module temp_limit_status_alert_test;
  import status_alert_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and wiring
  // ------------------------------------------------------------
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic conv_busy = 1'b0;
  logic conv_done = 1'b0;
  logic open_circuit = 1'b0;
  logic [7:0] local_temp = 8'h1E;
  logic [7:0] remote_temp = 8'h28;
  logic alert_suppress_bit = 1'b0;
  logic pin_function_select = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] local_crit_lim = 8'h50;
  logic [7:0] crit_hyst = 8'h05;
  wire logic reg_rd;
  wire logic addr_read;
  wire logic status_rvalid;
  wire logic shared_alert_n;
  wire logic crit_n;
  wire logic [7:0] reg_ptr;
  wire logic [7:0] status_rdata;
  logic [7:0] rd;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;
  // Each row leaves one flag set once the condition is gone
  logic [7:0] lt_tab [5] = '{8'h3C, 8'h05, 8'h1E, 8'h1E, 8'h1E};
  logic [7:0] rt_tab [5] = '{8'h28, 8'h28, 8'h46, 8'h0A, 8'h28};
  logic oc_tab [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] want_tab [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04};

  always #5 clock = ~clock;

  temp_limit_status_alert i_dut (
    .clock(clock),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .conv_busy(conv_busy),
    .conv_done(conv_done),
    .open_circuit(open_circuit),
    .local_temp(local_temp),
    .remote_temp(remote_temp),
    .local_high_lim(8'h32),
    .local_low_lim(8'h0A),
    .remote_high_lim(8'h3C),
    .remote_low_lim(8'h14),
    .local_crit_lim(local_crit_lim),
    .remote_crit_lim(8'h5A),
    .crit_hyst(crit_hyst),
    .alert_suppress_bit(alert_suppress_bit),
    .pin_function_select(pin_function_select),
    .reg_rd(reg_rd),
    .reg_ptr(reg_ptr),
    .addr_read(addr_read),
    .status_rdata(status_rdata),
    .status_rvalid(status_rvalid),
    .shared_alert_n(shared_alert_n),
    .critical_overheat_output_n(crit_n)
  );

  alert_host_model i_host (
    .clock(clock),
    .reg_rd(reg_rd),
    .reg_ptr(reg_ptr),
    .addr_read(addr_read),
    .status_rdata(status_rdata),
    .status_rvalid(status_rvalid)
  );

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic expect_status(input logic [7:0] want);
    i_host.read_reg(STATUS_PTR, rd);
    check(rd, want);
  endtask

  task automatic expect_pins(input logic alert_n, input logic crit);
    check({6'h00, shared_alert_n, crit_n}, {6'h00, alert_n, crit});
  endtask

  // Results are only valid in the strobe cycle; the wait covers +3
  task automatic convert(input logic [7:0] lt, input logic [7:0] rt,
                         input logic oc);
    @(negedge clock);
    local_temp = lt;
    remote_temp = rt;
    open_circuit = oc;
    conv_done = 1'b1;
    @(negedge clock);
    conv_done = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      summarize();
    end
  end

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    expect_pins(1'b1, 1'b1);
    expect_status(8'h00);
    conv_busy = 1'b1;
    expect_status(8'h80);
    conv_busy = 1'b0;
    i_host.read_reg(8'h03, rd);
    check(rd, 8'h00);
    $display("test reset_and_busy done");
    // A conversion strobe while frozen must leave no trace
    clk_en = 1'b0;
    convert(8'h3C, 8'h28, 1'b0);
    clk_en = 1'b1;
    expect_pins(1'b1, 1'b1);
    expect_status(8'h00);
    $display("test clock_enable done");
    for (int i = 0; i < 5; i++) begin
      convert(lt_tab[i], rt_tab[i], oc_tab[i]);
      expect_pins(1'b0, 1'b1);
      convert(8'h1E, 8'h28, 1'b0);
      expect_status(want_tab[i]);
      expect_status(8'h00);
      expect_pins(1'b0, 1'b1);
      i_host.service();
      expect_pins(1'b1, 1'b1);
    end
    $display("test sticky_flags done");
    convert(8'h3C, 8'h28, 1'b0);
    expect_status(8'h40);
    expect_status(8'h40);
    i_host.service();
    expect_pins(1'b0, 1'b1);
    convert(8'h1E, 8'h28, 1'b0);
    expect_status(8'h40);
    expect_status(8'h00);
    i_host.service();
    expect_pins(1'b1, 1'b1);
    $display("test cause_present done");
    convert(8'h55, 8'h28, 1'b0);
    expect_pins(1'b0, 1'b0);
    expect_status(8'h41);
    convert(8'h4C, 8'h28, 1'b0);
    expect_status(8'h41);
    expect_pins(1'b0, 1'b0);
    convert(8'h4B, 8'h28, 1'b0);
    expect_status(8'h40);
    expect_pins(1'b0, 1'b1);
    convert(8'h1E, 8'h5F, 1'b0);
    expect_pins(1'b0, 1'b0);
    expect_status(8'h52);
    convert(8'h1E, 8'h28, 1'b0);
    expect_status(8'h10);
    expect_pins(1'b0, 1'b1);
    expect_status(8'h00);
    i_host.service();
    // Zero hysteresis: release exactly at the limit
    crit_hyst = 8'h00;
    local_crit_lim = 8'h28;
    convert(8'h29, 8'h28, 1'b0);
    expect_pins(1'b1, 1'b0);
    expect_status(8'h01);
    convert(8'h28, 8'h28, 1'b0);
    expect_pins(1'b1, 1'b1);
    expect_status(8'h00);
    crit_hyst = 8'h05;
    local_crit_lim = 8'h50;
    $display("test critical done");
    alert_suppress_bit = 1'b1;
    convert(8'h3C, 8'h28, 1'b0);
    expect_pins(1'b1, 1'b1);
    alert_suppress_bit = 1'b0;
    repeat (3) @(negedge clock);
    expect_pins(1'b0, 1'b1);
    convert(8'h1E, 8'h28, 1'b0);
    expect_status(8'h40);
    expect_status(8'h00);
    i_host.service();
    $display("test mask done");
    pin_function_select = 1'b1;
    alert_suppress_bit = 1'b1;
    convert(8'h05, 8'h28, 1'b0);
    expect_pins(1'b1, 1'b1);
    expect_status(8'h20);
    convert(8'h1E, 8'h28, 1'b0);
    expect_status(8'h00);
    convert(8'h3C, 8'h28, 1'b0);
    expect_pins(1'b0, 1'b1);
    expect_status(8'h40);
    convert(8'h30, 8'h28, 1'b0);
    expect_pins(1'b0, 1'b1);
    convert(8'h2D, 8'h28, 1'b0);
    expect_pins(1'b1, 1'b1);
    expect_status(8'h00);
    convert(8'h1E, 8'h28, 1'b1);
    convert(8'h1E, 8'h28, 1'b0);
    expect_status(8'h04);
    expect_status(8'h00);
    pin_function_select = 1'b0;
    alert_suppress_bit = 1'b0;
    repeat (3) @(negedge clock);
    expect_pins(1'b0, 1'b1);
    i_host.service();
    expect_pins(1'b1, 1'b1);
    $display("test second_output done");
    summarize();
  end
endmodule

`default_nettype wire

// ### verilog/temp_limit_status_alert.sv
`timescale 1ns/10ps
`default_nettype none

module temp_limit_status_alert
  import status_alert_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clk_en,
  // Converter side
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic open_circuit,
  input wire logic [status_alert_pkg::DATA_W-1:0] local_temp,
  input wire logic [status_alert_pkg::DATA_W-1:0] remote_temp,
  // Programmed limits and hysteresis
  input wire logic [status_alert_pkg::DATA_W-1:0] local_high_lim,
  input wire logic [status_alert_pkg::DATA_W-1:0] local_low_lim,
  input wire logic [status_alert_pkg::DATA_W-1:0] remote_high_lim,
  input wire logic [status_alert_pkg::DATA_W-1:0] remote_low_lim,
  input wire logic [status_alert_pkg::DATA_W-1:0] local_crit_lim,
  input wire logic [status_alert_pkg::DATA_W-1:0] remote_crit_lim,
  input wire logic [status_alert_pkg::DATA_W-1:0] crit_hyst,
  // Configuration bits
  input wire logic alert_suppress_bit,
  input wire logic pin_function_select,
  // Serial interface side
  input wire logic reg_rd,
  input wire logic [7:0] reg_ptr,
  input wire logic addr_read,
  output var logic [status_alert_pkg::DATA_W-1:0] status_rdata,
  output var logic status_rvalid,
  // Pins
  output var logic shared_alert_n,
  output var logic critical_overheat_output_n
);
  import status_alert_pkg::*;

  // ----------------------------------------------------------------
  // Limit comparison on conversion results
  // ----------------------------------------------------------------
  logic [4:0] cause_q;
  logic [4:0] cause_d;
  logic [4:0] flags_q;
  logic [4:0] flags_d;
  logic [TRIP_N-1:0] trip_q;
  logic alert_q;
  logic alert_d;
  wire second_overheat_output_mode = pin_function_select;
  wire status_read = reg_rd && (reg_ptr == STATUS_PTR);

  assign cause_d[F_LOCAL_OVER] = local_temp > local_high_lim;
  assign cause_d[F_LOCAL_UNDER] = local_temp < local_low_lim;
  assign cause_d[F_REMOTE_OVER] = remote_temp > remote_high_lim;
  assign cause_d[F_REMOTE_UNDER] = remote_temp < remote_low_lim;
  assign cause_d[F_OPEN] = open_circuit;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cause_q <= FLAGS_RESET;
    end else if (clk_en && conv_done) begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------------
  // Hysteresis trackers: critical and second overheat
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] trk_temp [TRIP_N];
  logic [DATA_W-1:0] trk_lim [TRIP_N];
  assign trk_temp[TRIP_LOCAL_CRIT] = local_temp;
  assign trk_temp[TRIP_REMOTE_CRIT] = remote_temp;
  assign trk_temp[TRIP_LOCAL_OVER] = local_temp;
  assign trk_temp[TRIP_REMOTE_OVER] = remote_temp;
  assign trk_lim[TRIP_LOCAL_CRIT] = local_crit_lim;
  assign trk_lim[TRIP_REMOTE_CRIT] = remote_crit_lim;
  assign trk_lim[TRIP_LOCAL_OVER] = local_high_lim;
  assign trk_lim[TRIP_REMOTE_OVER] = remote_high_lim;

  genvar gi;
  generate
    for (gi = 0; gi < TRIP_N; gi = gi + 1) begin : g_trip
      // Floor at zero so a large hysteresis cannot wrap the threshold
      wire [DATA_W-1:0] release_lvl = (trk_lim[gi] >= crit_hyst) ?
        DATA_W'(trk_lim[gi] - crit_hyst) : '0;
      wire trip_set = trk_temp[gi] > trk_lim[gi];
      wire trip_clr = trk_temp[gi] <= release_lvl;
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          trip_q[gi] <= 1'b0;
        end else if (clk_en && conv_done) begin
          if (trip_set) begin
            trip_q[gi] <= 1'b1;
          end else if (trip_clr) begin
            trip_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Five status flags
  // ----------------------------------------------------------------
  // read clears only vanished causes
  wire [4:0] sticky = cause_q | (flags_q & ~({5{status_read}} & ~cause_q));

  // alert mode keeps all five sticky
  // second mode keeps only the open flag sticky
  // high flags from the high-limit trackers
  assign flags_d[F_LOCAL_OVER] = second_overheat_output_mode ?
    trip_q[TRIP_LOCAL_OVER] : sticky[F_LOCAL_OVER];
  assign flags_d[F_LOCAL_UNDER] = second_overheat_output_mode ?
    cause_q[F_LOCAL_UNDER] : sticky[F_LOCAL_UNDER];
  assign flags_d[F_REMOTE_OVER] = second_overheat_output_mode ?
    trip_q[TRIP_REMOTE_OVER] : sticky[F_REMOTE_OVER];
  assign flags_d[F_REMOTE_UNDER] = second_overheat_output_mode ?
    cause_q[F_REMOTE_UNDER] : sticky[F_REMOTE_UNDER];
  assign flags_d[F_OPEN] = sticky[F_OPEN];

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flags_q <= FLAGS_RESET;
    end else if (clk_en) begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // Alert latch
  // ----------------------------------------------------------------
  wire any_flag = |flags_q;
  wire any_cause = |cause_q;
  // status reads do not appear in the release term
  // release on address read only when all is clear
  assign alert_d = any_flag || (alert_q && !(addr_read && !any_cause));

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      alert_q <= 1'b0;
    end else if (clk_en) begin
      alert_q <= alert_d;
    end
  end

  // ----------------------------------------------------------------
  // Status read port
  // ----------------------------------------------------------------
  // busy straight from the converter
  wire [7:0] status_word = {conv_busy, flags_q,
    trip_q[TRIP_REMOTE_CRIT], trip_q[TRIP_LOCAL_CRIT]};

  // only pointer 02h answers; others read as zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      status_rdata <= RDATA_RESET;
      status_rvalid <= 1'b0;
    end else if (clk_en) begin
      status_rvalid <= reg_rd;
      if (reg_rd) begin
        status_rdata <= status_read ? status_word : RDATA_RESET;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  wire crit_any = trip_q[TRIP_LOCAL_CRIT] || trip_q[TRIP_REMOTE_CRIT];
  // low flags never reach the second overheat pin
  wire over_any = trip_q[TRIP_LOCAL_OVER] || trip_q[TRIP_REMOTE_OVER];
  // suppress bit matters only in alert mode
  wire alert_drive = alert_q && !alert_suppress_bit;
  wire shared_d = second_overheat_output_mode ? !over_any : !alert_drive;

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shared_alert_n <= PIN_IDLE;
      critical_overheat_output_n <= PIN_IDLE;
    end else if (clk_en) begin
      shared_alert_n <= shared_d;
      critical_overheat_output_n <= !crit_any;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_local_crit_trip;
    clk_en && conv_done && (local_temp > local_crit_lim);
  endsequence

  sequence s_crit_pin_low;
    trip_q[TRIP_LOCAL_CRIT] ##1 !critical_overheat_output_n;
  endsequence

  property p_busy_bit;
    clk_en && status_read |=> status_rdata[BIT_BUSY] == $past(conv_busy);
  endproperty
  a_busy_bit: assert property (p_busy_bit)
    else $error("busy bit does not match converter");

  property p_local_over_set;
    clk_en && conv_done && !second_overheat_output_mode && (local_temp > local_high_lim)
      ##1 clk_en |=> flags_q[F_LOCAL_OVER];
  endproperty
  a_local_over_set: assert property (p_local_over_set)
    else $error("local over flag not set after exceedance");

  property p_read_keeps_cause;
    clk_en && status_read && !second_overheat_output_mode && cause_q[F_LOCAL_OVER]
      |=> flags_q[F_LOCAL_OVER];
  endproperty
  a_read_keeps_cause: assert property (p_read_keeps_cause)
    else $error("flag cleared while its cause remains");

  property p_read_clears;
    clk_en && status_read && !second_overheat_output_mode && !cause_q[F_LOCAL_UNDER]
      |=> !flags_q[F_LOCAL_UNDER];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read failed to clear a stale flag");

  property p_alert_sticky;
    clk_en && !status_read && !second_overheat_output_mode && flags_q[F_LOCAL_UNDER]
      |=> flags_q[F_LOCAL_UNDER];
  endproperty
  a_alert_sticky: assert property (p_alert_sticky)
    else $error("flag dropped without a status read");

  property p_open_sticky;
    clk_en && !status_read && flags_q[F_OPEN] |=> flags_q[F_OPEN];
  endproperty
  a_open_sticky: assert property (p_open_sticky)
    else $error("open flag dropped without a status read");

  property p_read_no_release;
    clk_en && status_read && !addr_read && alert_q |=> alert_q;
  endproperty
  a_read_no_release: assert property (p_read_no_release)
    else $error("status read released the alert latch");

  property p_addr_release;
    clk_en && addr_read && !any_flag && !any_cause |=> !alert_q;
  endproperty
  a_addr_release: assert property (p_addr_release)
    else $error("address read did not release a clear latch");

  property p_alert_pin;
    clk_en && !second_overheat_output_mode && !alert_suppress_bit && alert_q
      |=> !shared_alert_n;
  endproperty
  a_alert_pin: assert property (p_alert_pin)
    else $error("alert pin not driven low with latch set");

  property p_mask;
    clk_en && !second_overheat_output_mode && alert_suppress_bit |=> shared_alert_n;
  endproperty
  a_mask: assert property (p_mask)
    else $error("suppressed alert pin went low");

  property p_crit_trip;
    s_local_crit_trip ##0 clk_en[*1] ##1 clk_en |-> s_crit_pin_low;
  endproperty
  a_crit_trip: assert property (p_crit_trip)
    else $error("critical trip did not pull the pin low");

  property p_second_overheat_output_pin;
    clk_en && second_overheat_output_mode && !over_any |=> shared_alert_n;
  endproperty
  a_second_overheat_output_pin: assert property (p_second_overheat_output_pin)
    else $error("second overheat pin low without trip");

endmodule

`default_nettype wire
